/* File: rtl/rseel_logger.sv */
// receive error event logger: status flags, misc counter and source id registers
//
// Notes on behaviour
// - status bits 4 to 0 always read zero.
// - status bits 5 to 11 latch one on their cell fault events.
// - writing one to status bits 5 to 15 clears that bit.
// - status bit 12 sets when the misc counter wraps.
// - status bit 13 sets when the underrun counter wraps.
// - status bit 14 sets when the overrun counter wraps.
// - status bit 15 sets while any of bits 14 to 5 is set.
// - misc id captures control structure address bits 19 to 4 on misc faults.
// - misc id updates only for faults whose select bit is set.
// - misc id also updates while the test bit is set.
// - misc counter increments on selected faults of bits 9 to 5.
// - misc counter also increments while the test bit is set.
// - underrun id captures control structure address on write underrun.
// - underrun id also updates while the test bit is set.
// - control bits 0 to 4 select which faults are miscellaneous.
// - enabled set flags drive the receive path service request.
// - control bit 15 forces all events, counters and id updates.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps

module rseel_logger (
  // clock and reset
  input  wire logic                          core_clk_in,
  input  wire logic                          reset_in,
  // register port
  input  wire logic [rseel_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [rseel_pkg::DATA_W-1:0]  reg_wdata_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  output logic      [rseel_pkg::DATA_W-1:0]  reg_rdata_out,
  // cell fault events
  input  wire logic [rseel_pkg::FAULT_N-1:0] cell_fault_in,
  input  wire logic [15:0]                   fault_source_id_in,
  input  wire logic                          underrun_counter_wrap_in,
  input  wire logic                          overrun_counter_wrap_in,
  // service and test
  output logic                               rx_path_service_request_out,
  output logic                               force_event_test_out
);

  logic [15:0]                   ctrl_q;
  logic [15:0]                   stat_q;
  logic [15:0]                   stat_d;
  logic [15:0]                   meid_q;
  logic [15:0]                   mect_q;
  logic [15:0]                   ueid_q;
  logic [15:0]                   rdata_q;
  logic [15:0]                   w1c;
  logic [rseel_pkg::FAULT_N-1:0] event_v;
  logic [9:0]                    flag_set;
  logic                          test_on;
  logic                          misc_hit;
  logic                          misc_wrap;
  logic                          under_hit;
  logic                          wr_ctrl;
  logic                          wr_stat;
  logic                          wr_meid;
  logic                          wr_mect;
  logic                          wr_ueid;

  // address match
  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  // write decode
  always_comb begin
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    wr_meid = 1'b0;
    wr_mect = 1'b0;
    wr_ueid = 1'b0;
    if (!reg_wr_in) begin
      wr_ctrl = 1'b0;
    end else if (addr_hit(reg_addr_in, rseel_pkg::CTRL_OFS)) begin
      wr_ctrl = 1'b1;
    end else if (addr_hit(reg_addr_in, rseel_pkg::STAT_OFS)) begin
      wr_stat = 1'b1;
    end else if (addr_hit(reg_addr_in, rseel_pkg::MEID_OFS)) begin
      wr_meid = 1'b1;
    end else if (addr_hit(reg_addr_in, rseel_pkg::MECT_OFS)) begin
      wr_mect = 1'b1;
    end else if (addr_hit(reg_addr_in, rseel_pkg::UEID_OFS)) begin
      wr_ueid = 1'b1;
    end
  end

  // event sources
  assign test_on   = ctrl_q[rseel_pkg::TEST_BIT];
  assign event_v   = cell_fault_in | {rseel_pkg::FAULT_N{test_on}};
  assign misc_hit  = (|(cell_fault_in[rseel_pkg::MISC_N-1:0] & ctrl_q[rseel_pkg::MISC_N-1:0]))
                     | test_on;
  assign misc_wrap = misc_hit && !wr_mect && (mect_q == rseel_pkg::CNT_MAX);
  assign under_hit = event_v[rseel_pkg::UNDERRUN_I];

  // status flag set terms, bits 14 down to 5
  assign flag_set = {overrun_counter_wrap_in | test_on,
                     underrun_counter_wrap_in | test_on,
                     misc_wrap | test_on,
                     event_v};

  // write one to clear mask
  assign w1c = wr_stat ? reg_wdata_in : rseel_pkg::ZERO_W;

  // next status: set beats clear
  always_comb begin
    stat_d = rseel_pkg::STAT_RST;
    stat_d[rseel_pkg::FLAG_HI:rseel_pkg::FAULT_LO] =
      (stat_q[rseel_pkg::FLAG_HI:rseel_pkg::FAULT_LO] & ~w1c[rseel_pkg::FLAG_HI:rseel_pkg::FAULT_LO])
      | flag_set;
    stat_d[rseel_pkg::SERV_BIT] = (stat_q[rseel_pkg::SERV_BIT] & ~w1c[rseel_pkg::SERV_BIT])
      | (|stat_d[rseel_pkg::FLAG_HI:rseel_pkg::FAULT_LO]);
  end

  // control register
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ctrl_q <= rseel_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata_in;
    end
  end

  // status register, low bits stay zero
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      stat_q <= rseel_pkg::STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // misc source id
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      meid_q <= rseel_pkg::MEID_RST;
    end else if (wr_meid) begin
      meid_q <= reg_wdata_in;
    end else if (misc_hit) begin
      meid_q <= fault_source_id_in;
    end
  end

  // misc counter
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mect_q <= rseel_pkg::MECT_RST;
    end else if (wr_mect) begin
      mect_q <= reg_wdata_in;
    end else if (misc_hit) begin
      mect_q <= mect_q + rseel_pkg::CNT_ONE;
    end
  end

  // underrun source id
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ueid_q <= rseel_pkg::UEID_RST;
    end else if (wr_ueid) begin
      ueid_q <= reg_wdata_in;
    end else if (under_hit) begin
      ueid_q <= fault_source_id_in;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rdata_q <= rseel_pkg::ZERO_W;
    end else if (!reg_rd_in) begin
      rdata_q <= rseel_pkg::ZERO_W;
    end else if (addr_hit(reg_addr_in, rseel_pkg::CTRL_OFS)) begin
      rdata_q <= ctrl_q;
    end else if (addr_hit(reg_addr_in, rseel_pkg::STAT_OFS)) begin
      rdata_q <= stat_q;
    end else if (addr_hit(reg_addr_in, rseel_pkg::MEID_OFS)) begin
      rdata_q <= meid_q;
    end else if (addr_hit(reg_addr_in, rseel_pkg::MECT_OFS)) begin
      rdata_q <= mect_q;
    end else if (addr_hit(reg_addr_in, rseel_pkg::UEID_OFS)) begin
      rdata_q <= ueid_q;
    end else begin
      rdata_q <= rseel_pkg::ZERO_W;
    end
  end

  // outputs
  assign reg_rdata_out = rdata_q;
  assign rx_path_service_request_out =
    |(stat_q[rseel_pkg::FLAG_HI:rseel_pkg::FAULT_LO] & ctrl_q[rseel_pkg::FLAG_HI:rseel_pkg::FAULT_LO]);
  assign force_event_test_out = test_on;

  // checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  property p_rsvd_zero;
    reg_rd_in && addr_hit(reg_addr_in, rseel_pkg::STAT_OFS) |=> reg_rdata_out[4:0] == 5'h00;
  endproperty
  rsvd_read_zero_a : assert property (p_rsvd_zero) else $error("status low bits not zero");

  property p_fault_latch;
    cell_fault_in != 7'h00 |=> (stat_q[11:5] & $past(cell_fault_in)) == $past(cell_fault_in);
  endproperty
  fault_latch_a : assert property (p_fault_latch) else $error("fault flag not latched");

  property p_w1c_clear;
    wr_stat && reg_wdata_in[5] && !event_v[0] |=> !stat_q[5];
  endproperty
  flag_w1c_a : assert property (p_w1c_clear) else $error("flag not cleared by one");

  property p_misc_wrap;
    misc_hit && !wr_mect && mect_q == 16'hffff |=> stat_q[12] && mect_q == 16'h0000;
  endproperty
  misc_wrap_a : assert property (p_misc_wrap) else $error("misc wrap not flagged");

  property p_under_wrap;
    underrun_counter_wrap_in |=> stat_q[13];
  endproperty
  under_wrap_a : assert property (p_under_wrap) else $error("underrun wrap not flagged");

  property p_over_wrap;
    overrun_counter_wrap_in |=> stat_q[14];
  endproperty
  over_wrap_a : assert property (p_over_wrap) else $error("overrun wrap not flagged");

  property p_serv_sum;
    stat_q[14:5] != 10'h000 |-> stat_q[15];
  endproperty
  serv_summary_a : assert property (p_serv_sum) else $error("service summary missing");

  property p_meid_cap;
    misc_hit && !wr_meid |=> meid_q == $past(fault_source_id_in);
  endproperty
  misc_id_capture_a : assert property (p_meid_cap) else $error("misc id not captured");

  property p_meid_hold;
    !(|(cell_fault_in[4:0] & ctrl_q[4:0])) && !test_on && !wr_meid |=> $stable(meid_q);
  endproperty
  misc_id_hold_a : assert property (p_meid_hold) else $error("misc id changed unselected");

  property p_test_id;
    test_on && !wr_meid && !wr_ueid |=> meid_q == $past(fault_source_id_in)
      && ueid_q == $past(fault_source_id_in);
  endproperty
  test_id_update_a : assert property (p_test_id) else $error("test did not update ids");

  property p_count_inc;
    misc_hit && !wr_mect |=> mect_q == $past(mect_q) + 16'h0001;
  endproperty
  misc_count_inc_a : assert property (p_count_inc) else $error("misc count not incremented");

  property p_count_hold;
    !misc_hit && !wr_mect |=> $stable(mect_q);
  endproperty
  misc_count_hold_a : assert property (p_count_hold) else $error("misc count changed idle");

  property p_test_count;
    test_on && !wr_mect ##1 test_on && !wr_mect |=> mect_q == $past(mect_q, 2) + 16'h0002;
  endproperty
  test_count_a : assert property (p_test_count) else $error("test count rate wrong");

  property p_ueid_cap;
    cell_fault_in[5] && !wr_ueid |=> ueid_q == $past(fault_source_id_in);
  endproperty
  under_id_capture_a : assert property (p_ueid_cap) else $error("underrun id not captured");

  property p_ueid_test;
    test_on && !wr_ueid |=> ueid_q == $past(fault_source_id_in);
  endproperty
  under_id_test_a : assert property (p_ueid_test) else $error("underrun id test update lost");

  property p_service;
    cell_fault_in[0] && ctrl_q[5] && !wr_ctrl |=> rx_path_service_request_out;
  endproperty
  service_request_a : assert property (p_service) else $error("service request not raised");

  property p_test_force;
    test_on |=> stat_q[14:5] == 10'h3ff && stat_q[15];
  endproperty
  test_force_a : assert property (p_test_force) else $error("test did not force events");

  property p_zero_write;
    wr_stat && reg_wdata_in == 16'h0000 && stat_q[15] |=> stat_q[15] && $past(stat_q[14:5]) ==
      ($past(stat_q[14:5]) & stat_q[14:5]);
  endproperty
  zero_write_a : assert property (p_zero_write) else $error("zero write changed flags");

  property p_set_wins;
    wr_stat && reg_wdata_in[6] && cell_fault_in[1] |=> stat_q[6];
  endproperty
  set_wins_a : assert property (p_set_wins) else $error("event lost to clear");

  property p_wrap_rate;
    mect_q == 16'hfffe && misc_hit && !wr_mect ##1 misc_hit && !wr_mect |=> mect_q == 16'h0000;
  endproperty
  wrap_rate_a : assert property (p_wrap_rate) else $error("counter wrap wrong");

  property p_misc_flag_src;
    !stat_q[12] && !misc_wrap && !test_on |=> !stat_q[12];
  endproperty
  misc_flag_source_a : assert property (p_misc_flag_src) else $error("misc wrap flag set unprompted");

  property p_under_flag_src;
    !stat_q[13] && !underrun_counter_wrap_in && !test_on |=> !stat_q[13];
  endproperty
  under_flag_source_a : assert property (p_under_flag_src) else $error("underrun wrap flag set unprompted");

  property p_over_flag_src;
    !stat_q[14] && !overrun_counter_wrap_in && !test_on |=> !stat_q[14];
  endproperty
  over_flag_source_a : assert property (p_over_flag_src) else $error("overrun wrap flag set unprompted");

  property p_ueid_hold;
    !cell_fault_in[5] && !test_on && !wr_ueid |=> $stable(ueid_q);
  endproperty
  under_id_hold_a : assert property (p_ueid_hold) else $error("underrun id changed idle");

  property p_flag_sticky;
    stat_q[5] && !(wr_stat && reg_wdata_in[5]) |=> stat_q[5];
  endproperty
  flag_sticky_a : assert property (p_flag_sticky) else $error("fault flag dropped");

  property p_fault_quiet;
    !stat_q[6] && !cell_fault_in[1] && !test_on |=> !stat_q[6];
  endproperty
  fault_quiet_a : assert property (p_fault_quiet) else $error("fault flag set unprompted");

  property p_full_clear;
    wr_stat && reg_wdata_in == 16'hffff && flag_set == 10'h000 |=> stat_q == 16'h0000;
  endproperty
  full_clear_a : assert property (p_full_clear) else $error("status not fully cleared");

  // main scenarios
  fault_seen_c : cover property (cell_fault_in != 7'h00 ##1 stat_q[15]);
  misc_wrap_c : cover property (misc_wrap ##1 stat_q[12]);
  test_mode_c : cover property (test_on ##1 test_on ##1 rx_path_service_request_out);
  clear_c : cover property (stat_q[15] ##1 wr_stat ##1 stat_q == 16'h0000);

endmodule

/* File: rtl/rseel_pkg.sv */
// offsets, field positions and reset values of the receive error event logger
package rseel_pkg;

  // data and address widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;

  // register offsets
  localparam logic [15:0] CTRL_OFS = 16'h3000;
  localparam logic [15:0] STAT_OFS = 16'h3002;
  localparam logic [15:0] MEID_OFS = 16'h3010;
  localparam logic [15:0] MECT_OFS = 16'h3012;
  localparam logic [15:0] UEID_OFS = 16'h3020;

  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [15:0] MEID_RST = 16'h0000;
  localparam logic [15:0] MECT_RST = 16'h0000;
  localparam logic [15:0] UEID_RST = 16'h0000;

  // cell fault inputs, in status bit order from bit 5
  localparam int FAULT_N    = 7;
  localparam int MISC_N     = 5;
  localparam int FAULT_LO   = 5;
  localparam int UNDERRUN_I = 5;

  // status and control fields
  localparam int MCR_BIT   = 12;
  localparam int URCR_BIT  = 13;
  localparam int ORCR_BIT  = 14;
  localparam int SERV_BIT  = 15;
  localparam int TEST_BIT  = 15;
  localparam int FLAG_HI   = 14;

  // counter limits
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] ZERO_W  = 16'h0000;

endpackage

/* File: testbench/rseel_logger_bench.sv */
// self-checking bench for the receive error event logger
`timescale 1ns/1ps

module rseel_logger_bench;
  logic        core_clk_in                 = 1'b0;
  logic        reset_in                    = 1'b1;
  logic [15:0] reg_addr_in                 = 16'h0000;
  logic [15:0] reg_wdata_in                = 16'h0000;
  logic        reg_wr_in                   = 1'b0;
  logic        reg_rd_in                   = 1'b0;
  logic [15:0] reg_rdata_out;
  logic [6:0]  cell_fault_in               = 7'h00;
  logic [15:0] fault_source_id_in          = 16'h0000;
  logic        underrun_counter_wrap_in    = 1'b0;
  logic        overrun_counter_wrap_in     = 1'b0;
  logic        rx_path_service_request_out;
  logic        force_event_test_out;
  logic [15:0] exp_ctrl                    = 16'h0000;
  logic [15:0] exp_stat                    = 16'h0000;
  logic [15:0] exp_meid                    = 16'h0000;
  logic [15:0] exp_mect                    = 16'h0000;
  logic [15:0] exp_ueid                    = 16'h0000;
  logic [15:0] rd_q;
  logic [15:0] tmp;
  integer      seed                        = 32'h78fbc76a;
  integer      miscompares                 = 0;
  integer      force_event_test_run                   = 0;
  integer      cycles                      = 0;

  rseel_logger rseel_logger_i (
    .core_clk_in                 (core_clk_in),
    .reset_in                    (reset_in),
    .reg_addr_in                 (reg_addr_in),
    .reg_wdata_in                (reg_wdata_in),
    .reg_wr_in                   (reg_wr_in),
    .reg_rd_in                   (reg_rd_in),
    .reg_rdata_out               (reg_rdata_out),
    .cell_fault_in               (cell_fault_in),
    .fault_source_id_in          (fault_source_id_in),
    .underrun_counter_wrap_in    (underrun_counter_wrap_in),
    .overrun_counter_wrap_in     (overrun_counter_wrap_in),
    .rx_path_service_request_out (rx_path_service_request_out),
    .force_event_test_out        (force_event_test_out)
  );

  always #20 core_clk_in = ~core_clk_in;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    force_event_test_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", force_event_test_run, miscompares);
    if (miscompares == 0 && force_event_test_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // summary bit follows any flag of 14 to 5, low bits zero
  function automatic logic [15:0] summ(input logic [15:0] s);
    summ = {s[15] | (|s[14:5]), s[14:5], 5'h00};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in    <= 1'b0;
    case (a)
      rseel_pkg::CTRL_OFS: exp_ctrl = d;
      rseel_pkg::STAT_OFS: exp_stat = summ(exp_stat & ~d);
      rseel_pkg::MEID_OFS: exp_meid = d;
      rseel_pkg::MECT_OFS: exp_mect = d;
      rseel_pkg::UEID_OFS: exp_ueid = d;
      default: ;
    endcase
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge core_clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in   <= 1'b0;
    #1 rd_q = reg_rdata_out;
  endtask

  task automatic pulse(input logic [6:0] f, input logic [1:0] w, input logic [15:0] id);
    @(posedge core_clk_in);
    cell_fault_in            <= f;
    underrun_counter_wrap_in <= w[0];
    overrun_counter_wrap_in  <= w[1];
    fault_source_id_in       <= id;
    @(posedge core_clk_in);
    cell_fault_in            <= 7'h00;
    underrun_counter_wrap_in <= 1'b0;
    overrun_counter_wrap_in  <= 1'b0;
    if ((f[4:0] & exp_ctrl[4:0]) != 5'h00) begin
      exp_meid = id;
      exp_mect = exp_mect + 16'h0001;
      exp_stat[12] = exp_stat[12] | (exp_mect == 16'h0000);
    end
    if (f[5]) begin
      exp_ueid = id;
    end
    exp_stat = summ(exp_stat | {1'b0, w, 1'b0, f, 5'h00});
    tmp = {15'h0000, |(exp_stat[14:5] & exp_ctrl[14:5])};
    #1 check("service", {15'h0000, rx_path_service_request_out}, tmp);
  endtask

  task automatic check_all();
    rd(rseel_pkg::CTRL_OFS);
    check("control", rd_q, exp_ctrl);
    rd(rseel_pkg::STAT_OFS);
    check("status", rd_q, exp_stat);
    rd(rseel_pkg::MEID_OFS);
    check("misc id", rd_q, exp_meid);
    rd(rseel_pkg::MECT_OFS);
    check("misc count", rd_q, exp_mect);
    rd(rseel_pkg::UEID_OFS);
    check("underrun id", rd_q, exp_ueid);
  endtask

  initial begin
    repeat (4) @(posedge core_clk_in);
    reset_in <= 1'b0;
    // reset values, write to an unmapped place
    check_all();
    wr(16'h3006, 16'hffff);
    check_all();
    // each fault alone, partial clears, zero writes
    wr(rseel_pkg::CTRL_OFS, 16'h7fff);
    rd(16'h3004);
    check("unmapped", rd_q, 16'h0000);
    rd(rseel_pkg::CTRL_OFS);
    check("control", rd_q, exp_ctrl);
    @(posedge core_clk_in);
    #1 check("rdata idle", reg_rdata_out, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      pulse(7'h01 << i, 2'b00, 16'h0a00 + 16'(i));
      wr(rseel_pkg::STAT_OFS, 16'h8000);
      wr(rseel_pkg::STAT_OFS, 16'h0000);
      check_all();
      wr(rseel_pkg::STAT_OFS, 16'h0001 << (5 + i));
      check_all();
      wr(rseel_pkg::STAT_OFS, 16'h8000);
    end
    // counter wrap and external wraps together
    wr(rseel_pkg::MECT_OFS, 16'hffff);
    pulse(7'h01, 2'b11, 16'h5a5a);
    check_all();
    wr(rseel_pkg::STAT_OFS, 16'hffff);
    // event in the same cycle as its clear
    @(posedge core_clk_in);
    reg_wr_in     <= 1'b1;
    reg_addr_in   <= rseel_pkg::STAT_OFS;
    reg_wdata_in  <= 16'hffff;
    cell_fault_in <= 7'h02;
    @(posedge core_clk_in);
    reg_wr_in     <= 1'b0;
    cell_fault_in <= 7'h00;
    exp_stat = 16'h8040;
    exp_meid = 16'h5a5a;
    exp_mect = exp_mect + 16'h0001;
    check_all();
    // random selects, enables, faults, wraps and clears
    for (int n = 0; n < 40; n++) begin
      wr(rseel_pkg::CTRL_OFS, 16'($random(seed)) & 16'h7fff);
      if (n % 8 == 3) begin
        wr(rseel_pkg::MECT_OFS, 16'hfffe);
      end
      repeat (3) pulse(7'($random(seed)), 2'($random(seed)), 16'($random(seed)));
      if (n % 2 == 1) begin
        wr(rseel_pkg::STAT_OFS, 16'($random(seed)));
      end
      check_all();
    end
    // test mode forces events, ids and counting
    @(posedge core_clk_in);
    fault_source_id_in <= 16'h3c3c;
    wr(rseel_pkg::CTRL_OFS, 16'h8000);
    #1 check("test out", {15'h0000, force_event_test_out}, 16'h0001);
    wr(rseel_pkg::MECT_OFS, 16'hfffe);
    rd(rseel_pkg::STAT_OFS);
    check("forced status", rd_q, 16'hffe0);
    rd(rseel_pkg::MEID_OFS);
    check("forced misc id", rd_q, 16'h3c3c);
    rd(rseel_pkg::UEID_OFS);
    check("forced underrun id", rd_q, 16'h3c3c);
    rd(rseel_pkg::MECT_OFS);
    tmp = rd_q;
    rd(rseel_pkg::MECT_OFS);
    check("forced count", rd_q, tmp + 16'h0002);
    wr(rseel_pkg::CTRL_OFS, 16'h0000);
    summarize();
  end
endmodule
